// ===== include/flc_map.svh
// register indices, reset values and timing constants of the flash led control block
// assumes a 25 MHz reference clock; included by bare name
`ifndef FLC_MAP_SVH
`define FLC_MAP_SVH

`define FLC_IDX_CMD 8'h00
`define FLC_IDX_DIM 8'h01
`define FLC_IDX_AUX 8'h02
`define FLC_IDX_STAT 8'h03
`define FLC_CMD_RST 8'h00
`define FLC_DIM_RST 8'h00
`define FLC_AUX_RST 8'h00
`define FLC_STAT_RST 8'h00
`define FLC_DEV_BASE 5'h0c
`define FLC_CLK_HZ 25000000
`define FLC_SUPPLY_LOW_MS 100
`define FLC_SUPPLY_LOW_CYC (`FLC_SUPPLY_LOW_MS * (`FLC_CLK_HZ / 1000))

`endif

// ===== include/flc_pkg.sv
// types shared by the flash led control block
// assumes nothing beyond a SystemVerilog compiler
package flc_pkg;

  // command register layout, msb first
  typedef struct packed {
    logic power_on_bit;
    logic trigger_enable_bit;
    logic torch_enable;
    logic ntc_enable;
    logic [3:0] flash_time;
  } flc_cmd_t;

  // dimming register layout
  typedef struct packed {
    logic [3:0] torch_level;
    logic [3:0] flash_level;
  } flc_dim_t;

  // one register write request
  typedef struct packed {
    logic en;
    logic [7:0] idx;
    logic [7:0] data;
  } flc_wr_t;

  typedef enum logic [2:0] {S_IDLE, S_DEV, S_SUB, S_WR, S_RD} flc_state_t;

endpackage

// ===== src/flc_sync.sv
// three-stage synchroniser with agreement filter for asynchronous pins
// assumes one clock domain and an active-low asynchronous reset
`timescale 1ns/10ps
module flc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // a change is taken only when stages two and three agree
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      s1_q <= RST;
      s2_q <= RST;
      s3_q <= RST;
      q <= RST;
    end
    else
    begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q <= (~(s2_q ^ s3_q) & s2_q) | ((s2_q ^ s3_q) & q);
    end

endmodule

// ===== src/flc_top.sv
// flash led control pin logic: two-wire slave, register file, wishbone slave, strap address
// assumes pins arrive asynchronous to REF_CLK and the wire level is resolved outside
`timescale 1ns/10ps
`include "flc_map.svh"

module flc_top #(
  parameter int unsigned SUPPLY_LOW_CYC = `FLC_SUPPLY_LOW_CYC
) (
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic SCL_I,
  input wire logic SDA_I,
  output wire logic SDA_O,
  output logic SDA_OE,
  input wire logic FLASH_TRIGGER_INPUT,
  input wire logic TRANSMIT_MASK_INPUT,
  input wire logic [1:0] ADDR_STRAP,
  input wire logic SUPPLY_LOW,
  input wire logic UVLO,
  input wire logic [7:0] STATUS_EVENT,
  output wire logic ATTENTION_N_O,
  output logic ATTENTION_N_OE,
  output logic FLASH_ACTIVE,
  output logic [3:0] FLASH_LEVEL,
  output logic CURRENT_CLAMP,
  output logic POWER_ON
);

  // ********************
  // pin synchronisation
  // ********************
  logic [7:0] pin_s;
  flc_sync #(.W(8), .RST(8'hc0)) u_sync (
    .clk(REF_CLK),
    .rst_n(RSTN),
    .d({SCL_I, SDA_I, FLASH_TRIGGER_INPUT, TRANSMIT_MASK_INPUT, ADDR_STRAP, SUPPLY_LOW, UVLO}),
    .q(pin_s)
  );

  // named views of the filtered pins
  wire scl_s = pin_s[7];
  wire sda_s = pin_s[6];
  wire trigger_s = pin_s[5];
  wire mask_s = pin_s[4];
  wire [1:0] strap_s = pin_s[3:2];
  wire supply_low_s = pin_s[1];
  wire uvlo_s = pin_s[0];

  // open drain: the driven level is always low
  assign SDA_O = 1'b0;
  assign ATTENTION_N_O = 1'b0;

  // ********************
  // register file
  // ********************
  flc_pkg::flc_cmd_t cmd_q;
  flc_pkg::flc_dim_t dim_q;
  logic [7:0] aux_q;
  logic [7:0] stat_q;
  flc_pkg::flc_wr_t i2c_wr_q;
  logic i2c_stat_rd_q;
  logic wb_ack_q;

  function automatic logic [7:0] rd_byte(input logic [7:0] idx, input logic [7:0] c, input logic [7:0] dm,
                                         input logic [7:0] ax, input logic [7:0] st);
    logic [7:0] r;
    r = 8'h00;
    case (idx)
      `FLC_IDX_CMD: r = c;
      `FLC_IDX_DIM: r = dm;
      `FLC_IDX_AUX: r = ax;
      `FLC_IDX_STAT: r = st;
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  // wishbone decode; unmapped words read zero and ignore writes
  wire wb_req = WB_CYC_I & WB_STB_I & ~wb_ack_q;
  wire [7:0] wb_idx = {2'b00, WB_ADR_I[7:2]};
  wire wb_wr = wb_req & WB_WE_I & WB_SEL_I[0];
  wire wb_rd = wb_req & ~WB_WE_I;
  wire [7:0] wb_rdata = rd_byte(wb_idx, cmd_q, dim_q, aux_q, stat_q);

  // the two-wire side wins a same-cycle collision; the bus write is then dropped
  flc_pkg::flc_wr_t wr;
  assign wr = i2c_wr_q.en ? i2c_wr_q : flc_pkg::flc_wr_t'{en: wb_wr, idx: wb_idx, data: WB_DAT_I[7:0]};
  wire stat_rd = i2c_stat_rd_q | (wb_rd & (wb_idx == `FLC_IDX_STAT));
  wire attn_d = (|STATUS_EVENT) | (ATTENTION_N_OE & ~stat_rd);

  // writable registers; status has no write path
  always_ff @(posedge REF_CLK or negedge RSTN)
    if (!RSTN)
    begin
      cmd_q <= `FLC_CMD_RST;
      dim_q <= `FLC_DIM_RST;
      aux_q <= `FLC_AUX_RST;
    end
    else if (wr.en)
    begin
      case (wr.idx)
        `FLC_IDX_CMD: cmd_q <= wr.data;
        `FLC_IDX_DIM: dim_q <= wr.data;
        `FLC_IDX_AUX: aux_q <= wr.data;
        default: ;
      endcase
    end

  // status events are sticky; a new event beats a clearing read
  always_ff @(posedge REF_CLK or negedge RSTN)
    if (!RSTN)
    begin
      stat_q <= `FLC_STAT_RST;
      ATTENTION_N_OE <= 1'b0;
    end
    else
    begin
      stat_q <= (stat_q & ~{8{stat_rd}}) | STATUS_EVENT;
      ATTENTION_N_OE <= attn_d;
    end

  // wishbone answer one cycle after the request is seen
  always_ff @(posedge REF_CLK or negedge RSTN)
    if (!RSTN)
    begin
      wb_ack_q <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_q <= wb_req;
      WB_DAT_O <= wb_rd ? {24'h00_0000, wb_rdata} : 32'h0000_0000;
    end
  assign WB_ACK_O = wb_ack_q;

  // flash control outputs
  always_ff @(posedge REF_CLK or negedge RSTN)
    if (!RSTN)
    begin
      FLASH_ACTIVE <= 1'b0;
      FLASH_LEVEL <= 4'h0;
      CURRENT_CLAMP <= 1'b0;
      POWER_ON <= 1'b0;
    end
    else
    begin
      FLASH_ACTIVE <= trigger_s & cmd_q.trigger_enable_bit & cmd_q.power_on_bit;
      FLASH_LEVEL <= dim_q.flash_level;
      CURRENT_CLAMP <= dim_q.flash_level[3] & mask_s;
      POWER_ON <= cmd_q.power_on_bit;
    end

  // ********************
  // slave address selection
  // ********************
  logic [1:0] addr_sel_q;
  logic adopted_q;
  logic boot_q;
  logic pulled_q;
  logic [21:0] low_cnt_q;
  wire [21:0] low_lim = SUPPLY_LOW_CYC[21:0];
  // a completed supply-low procedure counts as a supply removal, so it may replace the boot address
  wire readopt = ~supply_low_s & pulled_q;
  wire [6:0] dev_addr = {`FLC_DEV_BASE, addr_sel_q};

  // the strap is frozen at adoption; only a completed supply-low procedure reopens it
  always_ff @(posedge REF_CLK or negedge RSTN)
    if (!RSTN)
    begin
      addr_sel_q <= 2'h0;
      adopted_q <= 1'b0;
      boot_q <= 1'b1;
      pulled_q <= 1'b0;
      low_cnt_q <= 22'h00_0000;
    end
    else
    begin
      boot_q <= 1'b0;
      low_cnt_q <= !supply_low_s ? 22'h00_0000 : (low_cnt_q == low_lim) ? low_cnt_q : low_cnt_q + 22'h00_0001;
      if (supply_low_s && low_cnt_q == low_lim)
        pulled_q <= 1'b1;
      if (boot_q && strap_s == 2'h0 && !adopted_q)
        adopted_q <= 1'b1;
      else if (readopt)
      begin
        adopted_q <= 1'b1;
        addr_sel_q <= strap_s;
        pulled_q <= 1'b0;
      end
    end

  // ********************
  // two-wire slave
  // ********************
  flc_pkg::flc_state_t st_q;
  logic [3:0] bitcnt_q;
  logic [7:0] shift_q;
  logic [7:0] sub_q;
  logic in_ack_q;
  logic scl_d_q;
  logic sda_d_q;
  wire scl_rise = scl_s & ~scl_d_q;
  wire scl_fall = ~scl_s & scl_d_q;
  wire start_c = scl_s & scl_d_q & sda_d_q & ~sda_s;
  wire stop_c = scl_s & scl_d_q & ~sda_d_q & sda_s;
  wire busy = st_q != flc_pkg::S_IDLE;
  wire is_rd = st_q == flc_pkg::S_RD;
  wire byte_end = busy & scl_fall & ~in_ack_q & (bitcnt_q == 4'h8);
  wire ack_end = busy & scl_fall & in_ack_q;
  wire addr_hit = (shift_q[7:1] == dev_addr) & ~uvlo_s;
  wire [7:0] i2c_rdata = rd_byte(sub_q, cmd_q, dim_q, aux_q, stat_q);

  always_ff @(posedge REF_CLK or negedge RSTN)
    if (!RSTN)
    begin
      scl_d_q <= 1'b1;
      sda_d_q <= 1'b1;
    end
    else
    begin
      scl_d_q <= scl_s;
      sda_d_q <= sda_s;
    end

  // sda is only ever pulled low after a falling clock edge is seen; start and stop also release it
  always_ff @(posedge REF_CLK or negedge RSTN)
    if (!RSTN)
    begin
      st_q <= flc_pkg::S_IDLE;
      bitcnt_q <= 4'h0;
      shift_q <= 8'h00;
      sub_q <= 8'h00;
      in_ack_q <= 1'b0;
      SDA_OE <= 1'b0;
      i2c_wr_q <= '0;
      i2c_stat_rd_q <= 1'b0;
    end
    else
    begin
      i2c_wr_q.en <= 1'b0;
      i2c_stat_rd_q <= 1'b0;
      if (start_c || stop_c)
      begin
        st_q <= start_c ? flc_pkg::S_DEV : flc_pkg::S_IDLE;
        bitcnt_q <= 4'h0;
        in_ack_q <= 1'b0;
        SDA_OE <= 1'b0;
      end
      else if (busy && scl_rise)
      begin
        if (in_ack_q && is_rd && sda_s)
          st_q <= flc_pkg::S_IDLE; // master declined more data
        else if (!in_ack_q && bitcnt_q != 4'h8)
        begin
          bitcnt_q <= bitcnt_q + 4'h1;
          if (!is_rd)
            shift_q <= {shift_q[6:0], sda_s};
        end
      end
      else if (byte_end)
      begin
        in_ack_q <= 1'b1;
        case (st_q)
          flc_pkg::S_DEV:
          begin
            SDA_OE <= addr_hit;
            st_q <= !addr_hit ? flc_pkg::S_IDLE : shift_q[0] ? flc_pkg::S_RD : flc_pkg::S_SUB;
          end
          flc_pkg::S_SUB:
          begin
            SDA_OE <= ~uvlo_s;
            sub_q <= shift_q;
            st_q <= uvlo_s ? flc_pkg::S_IDLE : flc_pkg::S_WR;
          end
          flc_pkg::S_WR:
          begin
            SDA_OE <= ~uvlo_s;
            i2c_wr_q <= '{en: ~uvlo_s, idx: sub_q, data: shift_q};
            sub_q <= sub_q + 8'h01;
          end
          default: SDA_OE <= 1'b0;
        endcase
      end
      else if (ack_end)
      begin
        in_ack_q <= 1'b0;
        bitcnt_q <= 4'h0;
        SDA_OE <= is_rd & ~i2c_rdata[7];
        if (is_rd)
        begin
          shift_q <= {i2c_rdata[6:0], 1'b0};
          sub_q <= sub_q + 8'h01;
          i2c_stat_rd_q <= sub_q == `FLC_IDX_STAT;
        end
      end
      else if (is_rd && scl_fall)
      begin
        SDA_OE <= ~shift_q[7];
        shift_q <= {shift_q[6:0], 1'b0};
      end
    end

  // ********************
  // checks
  // ********************
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RSTN);

  sequence gate_open;
    trigger_s && cmd_q.trigger_enable_bit && cmd_q.power_on_bit;
  endsequence
  sequence ack_slot;
    byte_end && st_q != flc_pkg::S_RD;
  endsequence

  flash_gate_a: assert property (FLASH_ACTIVE |-> $past(trigger_s & cmd_q.trigger_enable_bit))
    else $error("flash active without trigger and enable");
  power_gate_a: assert property (gate_open |=> FLASH_ACTIVE)
    else $error("flash not started with gate open");
  attn_set_a: assert property ((|STATUS_EVENT) |=> ATTENTION_N_OE ##1 (ATTENTION_N_OE || $past(stat_rd)))
    else $error("attention not raised by status event");
  attn_clear_a: assert property (stat_rd && !(|STATUS_EVENT) |=> !ATTENTION_N_OE)
    else $error("attention not released by status read");
  attn_hold_a: assert property (ATTENTION_N_OE && !stat_rd |=> ATTENTION_N_OE)
    else $error("attention dropped without status read");
  addr_ack_a: assert property (byte_end && st_q == flc_pkg::S_DEV && shift_q[7:1] == {5'h0c, addr_sel_q}
                               && !uvlo_s |=> SDA_OE)
    else $error("own address not acknowledged");
  uvlo_ack_a: assert property (ack_slot ##0 uvlo_s |=> !SDA_OE)
    else $error("acknowledge given under lockout");
  sda_change_a: assert property ($changed(SDA_OE) |-> !scl_s || !SDA_OE)
    else $error("data line driven while clock high");
  boot_addr_a: assert property (boot_q && strap_s == 2'h0 |=> adopted_q && addr_sel_q == 2'h0)
    else $error("ground strap address not taken at start");
  strap_keep_a: assert property (adopted_q && !readopt |=> adopted_q && $stable(addr_sel_q))
    else $error("adopted address changed");
  strap_adopt_a: assert property (readopt |=> adopted_q && addr_sel_q == $past(strap_s))
    else $error("strap address not adopted after supply procedure");
  clamp_a: assert property (dim_q.flash_level[3] && mask_s |=> CURRENT_CLAMP)
    else $error("current clamp missing");

endmodule

// ===== testbench/flc_host.sv
// two-wire bus master model: drives the link clock and pulls the data line low
// assumes the bench resolves the data wire with a pull-up from all pull-downs
`timescale 1ns/10ps
module flc_host (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_oe
);
  // ****************
  // bit level tasks
  // ****************
  initial
  begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask
  // 320 ns bit, low 6 high 2: the slave answers five cycles after scl falls, so scl must rise after that
  task automatic bit_x(input logic b, output logic s);
    scl <= 1'b0;
    w(2);
    sda_oe <= ~b;
    w(4);
    scl <= 1'b1;
    w(1);
    s = sda;
    w(1);
  endtask
  // also a repeated start; afterwards the clock stands high
  task automatic start();
    scl <= 1'b0;
    w(4);
    sda_oe <= 1'b0;
    w(4);
    scl <= 1'b1;
    w(4);
    sda_oe <= 1'b1;
    w(4);
  endtask
  task automatic stop();
    scl <= 1'b0;
    w(4);
    sda_oe <= 1'b1;
    w(4);
    scl <= 1'b1;
    w(4);
    sda_oe <= 1'b0;
    w(4);
  endtask
  // msb first, then the ack bit
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(d[i], s);
    bit_x(1'b1, s);
    ack = ~s;
  endtask
  task automatic rbyte(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(~more, s);
  endtask
endmodule

// ===== testbench/flc_top_tb.sv
// self-checking bench of the flash led control block: wishbone, pins and two-wire link
// assumes flc_host as bus master; pins reach the design asynchronously
`timescale 1ns/10ps
`include "flc_map.svh"
module flc_top_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic fire_in = 1'b0;
  logic mask = 1'b0;
  logic [1:0] strap = 2'h0;
  logic sup_low = 1'b0;
  logic uvlo = 1'b0;
  logic [7:0] ev = 8'h00;
  logic [31:0] rnd = 32'hc791;
  logic [31:0] exp_q[$];
  logic ack;
  logic [7:0] rdat;
  int bad_count = 0;
  int n_tests = 0;
  int cnt = 0;
  wire logic scl;
  wire logic h_oe;
  wire logic [31:0] dat_o;
  wire logic ack_o, sda_o, sda_oe, attn_o, attn_oe, fl_act, clamp, pwr;
  wire logic [3:0] fl_lvl;
  // pull-up: either party pulling low wins
  wire logic sda = ~(sda_oe | h_oe);
  // ****************
  // harness
  // ****************
  flc_top #(.SUPPLY_LOW_CYC(20)) i_dut (
    .REF_CLK(clk), .RSTN(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack_o), .SCL_I(scl), .SDA_I(sda),
    .SDA_O(sda_o), .SDA_OE(sda_oe), .FLASH_TRIGGER_INPUT(fire_in), .TRANSMIT_MASK_INPUT(mask),
    .ADDR_STRAP(strap), .SUPPLY_LOW(sup_low), .UVLO(uvlo), .STATUS_EVENT(ev), .ATTENTION_N_O(attn_o),
    .ATTENTION_N_OE(attn_oe), .FLASH_ACTIVE(fl_act), .FLASH_LEVEL(fl_lvl), .CURRENT_CLAMP(clamp),
    .POWER_ON(pwr)
  );
  flc_host i_host (.clk(clk), .sda(sda), .scl(scl), .sda_oe(h_oe));
  initial
  begin
    forever #20 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic complete_run();
    if (bad_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask
  // classic cycle: hold everything until ack is sampled, then release
  task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= a;
    dat <= d;
    sel <= 4'h1;
    do @(posedge clk); while (ack_o !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask
  task automatic probe(input logic [1:0] s, input logic e);
    i_host.start();
    i_host.wbyte({`FLC_DEV_BASE, s, 1'b0}, ack);
    i_host.stop();
    chk("addr_ack", e, ack);
  endtask
  // read answers are compared against the oldest note; also the hang limit
  always @(posedge clk)
  begin
    cnt++;
    if (ack_o === 1'b1 && we === 1'b0 && exp_q.size() > 0)
      chk("wb_read", exp_q.pop_front(), dat_o);
    if (cnt == 20000)
    begin
      bad_count++;
      complete_run();
    end
  end
  // ****************
  // main sequence
  // ****************
  initial
  begin
    w(6);
    rst_n <= 1'b1;
    w(2);
    chk("attn", 1'b0, attn_oe);
    wb(1'b1, 8'h0c, 32'hff);
    rd(8'h0c, 32'h0);
    rd(8'h14, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      rnd = lfsr(rnd);
      wb(1'b1, 8'h08, rnd);
      rd(8'h08, {24'h0, rnd[7:0]});
    end
    for (int i = 0; i < 8; i++)
    begin
      wb(1'b1, 8'h00, {24'h0, i[2:1], 6'h00});
      fire_in <= i[0];
      w(10);
      chk("flash_active", i[2] & i[1] & i[0], fl_act);
      chk("power_on", i[2], pwr);
    end
    rd(8'h00, 32'hc0);
    wb(1'b1, 8'h04, 32'h08);
    w(10);
    chk("clamp", 1'b0, clamp);
    mask <= 1'b1;
    w(10);
    chk("clamp", 1'b1, clamp);
    chk("level", 4'h8, fl_lvl);
    wb(1'b1, 8'h04, 32'h07);
    w(2);
    chk("clamp", 1'b0, clamp);
    // status events latch attention until a status read
    ev <= 8'h05;
    w(1);
    ev <= 8'h00;
    w(3);
    chk("attn", 1'b1, attn_oe);
    chk("attn_pin", 1'b0, attn_o);
    chk("sda_pin", 1'b0, sda_o);
    ev <= 8'h10;
    w(1);
    ev <= 8'h00;
    w(3);
    chk("attn", 1'b1, attn_oe);
    rd(8'h0c, 32'h15);
    w(1);
    chk("attn", 1'b0, attn_oe);
    rd(8'h0c, 32'h0);
    // two-wire write, then repeated-start read back
    i_host.start();
    i_host.wbyte({`FLC_DEV_BASE, 2'b00, 1'b0}, ack);
    chk("addr_ack", 1'b1, ack);
    i_host.wbyte(8'h01, ack);
    i_host.wbyte(8'h5a, ack);
    chk("data_ack", 1'b1, ack);
    i_host.stop();
    rd(8'h04, 32'h5a);
    chk("level", 4'ha, fl_lvl);
    i_host.start();
    i_host.wbyte({`FLC_DEV_BASE, 2'b00, 1'b0}, ack);
    i_host.wbyte(8'h01, ack);
    i_host.start();
    i_host.wbyte({`FLC_DEV_BASE, 2'b00, 1'b1}, ack);
    i_host.rbyte(1'b0, rdat);
    i_host.stop();
    chk("link_read", 8'h5a, rdat);
    probe(2'b01, 1'b0);
    uvlo <= 1'b1;
    w(8);
    probe(2'b00, 1'b0);
    uvlo <= 1'b0;
    strap <= 2'b01;
    w(8);
    probe(2'b00, 1'b1);
    sup_low <= 1'b1;
    w(10);
    sup_low <= 1'b0;
    w(8);
    probe(2'b00, 1'b1);
    sup_low <= 1'b1;
    w(30);
    sup_low <= 1'b0;
    w(8);
    strap <= 2'b10;
    w(8);
    probe(2'b01, 1'b1);
    probe(2'b00, 1'b0);
    probe(2'b10, 1'b0);
    chk("pending_reads", 32'h0, exp_q.size());
    complete_run();
  end
endmodule
